/* File: hdl/ppx_crossbar.sv */
// Priority crossbar and port control for four 8-bit ports, with AXI4-Lite registers.
// Pins arrive as input/output/enable/pullup vectors; the pad ring resolves the wire.
`timescale 1ns/1ps
`default_nettype none
module ppx_crossbar (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Peripheral outputs
    input wire logic first_uart_transmit,
    input wire logic first_uart_receive_out,
    input wire logic first_uart_mode0,
    input wire logic sda_out,
    input wire logic scl_out,
    input wire logic second_uart_transmit,
    input wire logic second_uart_receive_out,
    input wire logic second_uart_mode0,
    // Peripheral inputs
    output logic first_uart_receive,
    output logic sda_in,
    output logic scl_in,
    output logic second_uart_receive,
    output logic int0_in,
    output logic int1_in,
    output logic adc_b_convert_start_input,
    // External memory port
    input wire logic memif_muxed,
    input wire logic external_data_move,
    input wire logic [31:0] memif_claim,
    input wire logic [31:0] memif_out,
    input wire logic [31:0] memif_drive,
    // Pins
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic [31:0] pin_pullup
);

    ppx_pkg::ppx_state_t s;
    ppx_pkg::ppx_state_t next_s;
    logic [ppx_pkg::NSIG-1:0] sig_en;
    logic [ppx_pkg::NSIG-1:0] sig_val;
    logic [ppx_pkg::NSIG-1:0] sig_drv;
    logic [ppx_pkg::NSIG-1:0] sig_od;
    logic [31:0] skip;
    logic [31:0] alloc;
    logic [3:0] sel_idx [ppx_pkg::NPIN];
    logic [5:0] srank [ppx_pkg::NSIG];

    // Register read decode: {resp, data}
    function automatic logic [33:0] reg_read(input logic [7:0] a,
                                             input ppx_pkg::ppx_state_t st);
        logic [31:0] lvl;
        logic [1:0] n;
        lvl = st.sync2 & st.imode;
        n = a[3:2];
        reg_read = {ppx_pkg::RESP_OKAY, 32'h00000000};
        if (a[7])
        begin
            reg_read[0] = lvl[a[6:2]];
        end
        else
        begin
            case (a[7:4])
                ppx_pkg::REGION_CFG:
                begin
                    if (a == ppx_pkg::ADDR_CFG_A) reg_read[7:0] = st.cfg_a;
                    else if (a == ppx_pkg::ADDR_CFG_B) reg_read[7:0] = st.cfg_b;
                    else if (a == ppx_pkg::ADDR_CFG_C) reg_read[7:0] = st.cfg_c;
                    else reg_read[33:32] = ppx_pkg::RESP_SLVERR;
                end
                ppx_pkg::REGION_PIN: reg_read[7:0] = lvl[n*8 +: 8];
                ppx_pkg::REGION_LATCH: reg_read[7:0] = st.latch[n*8 +: 8];
                ppx_pkg::REGION_OMODE: reg_read[7:0] = st.omode[n*8 +: 8];
                ppx_pkg::REGION_IMODE: reg_read[7:0] = st.imode[n*8 +: 8];
                default: reg_read[33:32] = ppx_pkg::RESP_SLVERR;
            endcase
        end
    endfunction : reg_read

    // Allocation, pin drive and bus handling all feed one next-state copy
    always_comb
    begin
        logic [5:0] cnt;
        logic [5:0] pr;
        logic [1:0] n;
        logic d;
        logic drv;
        logic od;
        logic ok;
        cnt = 6'h00;
        pr = 6'h00;
        n = 2'b00;
        d = 1'b0;
        drv = 1'b0;
        od = 1'b0;
        ok = 1'b0;
        next_s = s;

        // Group enables: a serial peripheral's signals share one bit
        sig_en = {s.cfg_c[ppx_pkg::CFGC_CNV_EN], s.cfg_b[ppx_pkg::CFGB_INT1_EN],
                  s.cfg_b[ppx_pkg::CFGB_INT0_EN], {2{s.cfg_c[ppx_pkg::CFGC_SU_EN]}},
                  {2{s.cfg_a[ppx_pkg::CFGA_SMB_EN]}},
                  {2{s.cfg_a[ppx_pkg::CFGA_FU_EN]}}};
        sig_val = {3'b111, second_uart_receive_out, second_uart_transmit, scl_out,
                   sda_out, first_uart_receive_out, first_uart_transmit};
        sig_drv = {3'b000, second_uart_mode0, 1'b1, 1'b1, 1'b1,
                   first_uart_mode0, 1'b1};
        sig_od = {3'b000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

        // Skip analog pins and the memory reservation
        skip = ~s.imode;
        if (s.cfg_c[ppx_pkg::CFGC_MEMIF_RES])
        begin
            skip[ppx_pkg::MEMIF_WR_PIN] = 1'b1;
            skip[ppx_pkg::MEMIF_RD_PIN] = 1'b1;
            if (memif_muxed) skip[ppx_pkg::MEMIF_ALE_PIN] = 1'b1;
        end

        // Rank of each enabled signal in priority order
        for (int i = 0; i < ppx_pkg::NSIG; i++)
        begin
            srank[i] = cnt;
            if (sig_en[i]) cnt = cnt + 6'h01;
        end

        // The k-th usable pin carries the k-th enabled signal; recomputed every cycle
        alloc = 32'h00000000;
        for (int p = 0; p < ppx_pkg::NPIN; p++)
        begin
            sel_idx[p] = 4'h0;
            if (!skip[p])
            begin
                for (int i = 0; i < ppx_pkg::NSIG; i++)
                begin
                    if (sig_en[i] && srank[i] == pr)
                    begin
                        alloc[p] = 1'b1;
                        sel_idx[p] = 4'(i);
                    end
                end
                pr = pr + 6'h01;
            end
        end

        // Pin synchronisers; a read just after a write still sees the old level
        next_s.sync1 = pin_in;
        next_s.sync2 = s.sync1;

        // Per-pin output, enable and pullup
        for (int p = 0; p < ppx_pkg::NPIN; p++)
        begin
            if (alloc[p])
            begin
                d = sig_val[sel_idx[p]];
                drv = sig_drv[sel_idx[p]];
                od = sig_od[sel_idx[p]] | ~s.omode[p];
            end
            else
            begin
                d = s.latch[p];
                drv = 1'b1;
                od = ~s.omode[p];
            end
            if (s.cfg_c[ppx_pkg::CFGC_MEMIF_RES] && external_data_move && memif_claim[p])
            begin
                d = memif_out[p];
                drv = memif_drive[p];
                od = ~s.omode[p];
            end
            ok = s.cfg_c[ppx_pkg::CFGC_GLOBAL_EN] & drv & (~d | ~od);
            next_s.pin_oe[p] = ok;
            next_s.pin_out[p] = ok & d;
            next_s.pin_pullup[p] = ~s.cfg_c[ppx_pkg::CFGC_PUD] & s.imode[p]
                                   & ~(ok & ~d);
        end

        // Deliver pin levels to peripheral inputs; idle high when unmapped
        next_s.in_sig = '1;
        for (int p = 0; p < ppx_pkg::NPIN; p++)
        begin
            if (alloc[p]) next_s.in_sig[sel_idx[p]] = s.sync2[p];
        end

        // Write address and data are taken independently
        if (awvalid && s.awready)
        begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = awaddr;
        end
        if (wvalid && s.wready)
        begin
            next_s.w_held = 1'b1;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        if (s.aw_held && s.w_held && !s.bvalid)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = ppx_pkg::RESP_OKAY;
            n = s.awaddr[3:2];
            if (s.awaddr[7])
            begin
                if (s.wstrb[0]) next_s.latch[s.awaddr[6:2]] = s.wdata[0];
            end
            else if (s.wstrb[0])
            begin
                case (s.awaddr[7:4])
                    ppx_pkg::REGION_CFG:
                    begin
                        if (s.awaddr == ppx_pkg::ADDR_CFG_A) next_s.cfg_a = s.wdata[7:0];
                        else if (s.awaddr == ppx_pkg::ADDR_CFG_B) next_s.cfg_b = s.wdata[7:0];
                        else if (s.awaddr == ppx_pkg::ADDR_CFG_C) next_s.cfg_c = s.wdata[7:0];
                        else next_s.bresp = ppx_pkg::RESP_SLVERR;
                    end
                    ppx_pkg::REGION_PIN: next_s.latch[n*8 +: 8] = s.wdata[7:0];
                    ppx_pkg::REGION_LATCH: next_s.latch[n*8 +: 8] = s.wdata[7:0];
                    ppx_pkg::REGION_OMODE: next_s.omode[n*8 +: 8] = s.wdata[7:0];
                    ppx_pkg::REGION_IMODE: next_s.imode[n*8 +: 8] = s.wdata[7:0];
                    default: next_s.bresp = ppx_pkg::RESP_SLVERR;
                endcase
            end
        end
        if (s.bvalid && bready) next_s.bvalid = 1'b0;
        next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
        next_s.wready = ~next_s.w_held & ~next_s.bvalid;

        // Read channel: one outstanding read
        if (arvalid && s.arready)
        begin
            next_s.rvalid = 1'b1;
            {next_s.rresp, next_s.rdata} = reg_read(araddr, s);
        end
        if (s.rvalid && rready) next_s.rvalid = 1'b0;
        next_s.arready = ~next_s.rvalid;
    end

    // Synchronous reset to documented defaults
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.cfg_a <= ppx_pkg::RST_CFG;
            s.cfg_b <= ppx_pkg::RST_CFG;
            s.cfg_c <= ppx_pkg::RST_CFG;
            s.latch <= ppx_pkg::RST_LATCH;
            s.omode <= ppx_pkg::RST_OMODE;
            s.imode <= ppx_pkg::RST_IMODE;
            s.pin_pullup <= '1;
            s.in_sig <= '1;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign pin_pullup = s.pin_pullup;
    assign first_uart_receive = s.in_sig[ppx_pkg::SIG_FU_RX];
    assign sda_in = s.in_sig[ppx_pkg::SIG_SDA];
    assign scl_in = s.in_sig[ppx_pkg::SIG_SCL];
    assign second_uart_receive = s.in_sig[ppx_pkg::SIG_SU_RX];
    assign int0_in = s.in_sig[ppx_pkg::SIG_INT0];
    assign int1_in = s.in_sig[ppx_pkg::SIG_INT1];
    assign adc_b_convert_start_input = s.in_sig[ppx_pkg::SIG_CNV];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Byte that a pin or latch read at the current address must return next cycle
    logic [7:0] pin_byte;
    logic [7:0] latch_byte;
    assign pin_byte = 8'((s.sync2 & s.imode) >> {araddr[3:2], 3'b000});
    assign latch_byte = 8'(s.latch >> {araddr[3:2], 3'b000});

    // Analog pins 0 or 1 would push the first UART further up, so they are excluded
    sequence s_fu_on;
        s.cfg_a[ppx_pkg::CFGA_FU_EN] && s.cfg_c[ppx_pkg::CFGC_GLOBAL_EN]
        && !external_data_move && s.imode[1:0] == 2'b11;
    endsequence
    sequence s_rd_at(logic [3:0] region);
        arvalid && arready && !araddr[7] && araddr[7:4] == region;
    endsequence

    property p_drivers_off;
        !s.cfg_c[ppx_pkg::CFGC_GLOBAL_EN] |=> pin_oe == 32'h00000000;
    endproperty
    a_drivers_off: assert property (p_drivers_off) else $error("driver on before enable");

    property p_fu_tx;
        s_fu_on |=> pin_out[0] == ($past(first_uart_transmit) & pin_oe[0]);
    endproperty
    a_fu_tx: assert property (p_fu_tx) else $error("first uart tx not on pin 0");

    property p_rx_in;
        s_fu_on ##0 !first_uart_mode0 |=> !pin_oe[1];
    endproperty
    a_rx_in: assert property (p_rx_in) else $error("input pin driven");

    property p_gpio;
        s.cfg_a == 8'h00 && s.cfg_b == 8'h00 && !external_data_move
        && !s.cfg_c[ppx_pkg::CFGC_SU_EN] && !s.cfg_c[ppx_pkg::CFGC_CNV_EN]
        && s.cfg_c[ppx_pkg::CFGC_GLOBAL_EN] |=> pin_out == ($past(s.latch) & pin_oe);
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio pin not from latch");

    property p_od;
        1'b1 |=> (pin_oe & pin_out & ~$past(s.omode)) == 32'h00000000;
    endproperty
    a_od: assert property (p_od) else $error("open-drain pin driven high");

    property p_pull_low;
        (pin_pullup & pin_oe & ~pin_out) == 32'h00000000;
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("pullup fights low drive");

    property p_analog;
        1'b1 |=> (pin_pullup & ~$past(s.imode)) == 32'h00000000
                 && (alloc & ~s.imode) == 32'h00000000;
    endproperty
    a_analog: assert property (p_analog) else $error("analog pin pulled or allocated");

    property p_reserve;
        s.cfg_c[ppx_pkg::CFGC_MEMIF_RES] |-> alloc[7:6] == 2'b00
            && !(memif_muxed && alloc[ppx_pkg::MEMIF_ALE_PIN]);
    endproperty
    a_reserve: assert property (p_reserve) else $error("reserved pin allocated");

    property p_pin_read;
        s_rd_at(ppx_pkg::REGION_PIN) |=> rvalid && rdata[7:0] == $past(pin_byte);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read mismatch");

    property p_rmw_read;
        s_rd_at(ppx_pkg::REGION_LATCH) |=> rdata[7:0] == $past(latch_byte);
    endproperty
    a_rmw_read: assert property (p_rmw_read) else $error("latch view wrong");

    property p_memif;
        s.cfg_c[ppx_pkg::CFGC_MEMIF_RES] && s.cfg_c[ppx_pkg::CFGC_GLOBAL_EN] && external_data_move
        |=> ((pin_out ^ $past(memif_out)) & pin_oe & $past(memif_claim)) == 32'h00000000;
    endproperty
    a_memif: assert property (p_memif) else $error("memory port not driving claimed pins");

endmodule : ppx_crossbar
`default_nettype wire

/* File: hdl/ppx_pkg.sv */
// Constants and state layout for the priority port crossbar.
// Assumes a single system clock and an AXI4-Lite master with 8-bit byte addresses.
package ppx_pkg;

    localparam int NPIN = 32;
    localparam int NSIG = 9;

    // Register byte addresses and regions (region is address bits 7:4)
    localparam logic [7:0] ADDR_CFG_A = 8'h00;
    localparam logic [7:0] ADDR_CFG_B = 8'h04;
    localparam logic [7:0] ADDR_CFG_C = 8'h08;
    localparam logic [3:0] REGION_CFG = 4'h0;
    localparam logic [3:0] REGION_PIN = 4'h1;
    localparam logic [3:0] REGION_LATCH = 4'h2;
    localparam logic [3:0] REGION_OMODE = 4'h3;
    localparam logic [3:0] REGION_IMODE = 4'h4;

    // Configuration bit positions
    localparam int CFGA_SMB_EN = 0;
    localparam int CFGA_FU_EN = 2;
    localparam int CFGB_INT0_EN = 2;
    localparam int CFGB_INT1_EN = 4;
    localparam int CFGC_CNV_EN = 0;
    localparam int CFGC_SU_EN = 2;
    localparam int CFGC_GLOBAL_EN = 4;
    localparam int CFGC_MEMIF_RES = 5;
    localparam int CFGC_PUD = 7;

    // Pins reserved for the memory interface on port 0
    localparam int MEMIF_ALE_PIN = 5;
    localparam int MEMIF_RD_PIN = 6;
    localparam int MEMIF_WR_PIN = 7;

    // Signal order = priority order
    localparam int SIG_FU_TX = 0;
    localparam int SIG_FU_RX = 1;
    localparam int SIG_SDA = 2;
    localparam int SIG_SCL = 3;
    localparam int SIG_SU_TX = 4;
    localparam int SIG_SU_RX = 5;
    localparam int SIG_INT0 = 6;
    localparam int SIG_INT1 = 7;
    localparam int SIG_CNV = 8;
    localparam logic [NSIG-1:0] SIG_INPUT_ONLY = 9'h1c0;

    // Reset values
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [31:0] RST_LATCH = 32'hffffffff;
    localparam logic [31:0] RST_OMODE = 32'h00000000;
    localparam logic [31:0] RST_IMODE = 32'hffffffff;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [7:0] cfg_a;
        logic [7:0] cfg_b;
        logic [7:0] cfg_c;
        logic [31:0] latch;
        logic [31:0] omode;
        logic [31:0] imode;
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] pin_out;
        logic [31:0] pin_oe;
        logic [31:0] pin_pullup;
        logic [NSIG-1:0] in_sig;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ppx_state_t;

endpackage : ppx_pkg

/* File: tb/ppx_pin_model.sv */
// Board model around the 32 port pins: works out each wire's level.
// Assumes the bench says which pins the board drives and to what level.
`timescale 1ns/1ps
`default_nettype none
module ppx_pin_model (
    // Clock
    input wire logic aclk,
    // Device side
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pin_pullup,
    // Board side
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_level,
    output logic [31:0] pin_in
);
    logic [31:0] flt = 32'h55555555;

    // A wire with no driver and no pullup wanders, so nothing may rely on it
    always_ff @(posedge aclk)
    begin
        flt <= ~flt;
    end

    // Device driver first, then the board, then the weak pullup
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_level[i];
            else if (pin_pullup[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = flt[i];
        end
    end
endmodule : ppx_pin_model
`default_nettype wire

/* File: tb/priority_port_crossbar_test.sv */
// Self-checking bench for the port crossbar, driven over AXI4-Lite.
// Assumes the pin model resolves the wires; pins settle a few edges after writes.
`timescale 1ns/1ps
`default_nettype none
module priority_port_crossbar_test;
    localparam logic [1:0] OK = ppx_pkg::RESP_OKAY;
    localparam logic [1:0] SE = ppx_pkg::RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic first_uart_transmit = 1'b1, first_uart_receive_out = 1'b1, first_uart_mode0 = 1'b0;
    logic sda_out = 1'b1, scl_out = 1'b1, second_uart_transmit = 1'b1;
    logic second_uart_receive_out = 1'b1, second_uart_mode0 = 1'b0;
    logic first_uart_receive, sda_in, scl_in, second_uart_receive;
    logic int0_in, int1_in, adc_b_convert_start_input;
    logic memif_muxed = 1'b0, external_data_move = 1'b0;
    logic [31:0] memif_claim = 32'h0, memif_out = 32'h0, memif_drive = 32'h0;
    logic [31:0] pin_in, pin_out, pin_oe, pin_pullup;
    logic [31:0] ext_en = 32'h0, ext_level = 32'h0;
    int error_cnt = 0;
    int n_compared = 0;

    ppx_crossbar ppx_crossbar_i (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .first_uart_transmit(first_uart_transmit),
        .first_uart_receive_out(first_uart_receive_out),
        .first_uart_mode0(first_uart_mode0), .sda_out(sda_out), .scl_out(scl_out),
        .second_uart_transmit(second_uart_transmit),
        .second_uart_receive_out(second_uart_receive_out),
        .second_uart_mode0(second_uart_mode0),
        .first_uart_receive(first_uart_receive), .sda_in(sda_in), .scl_in(scl_in),
        .second_uart_receive(second_uart_receive), .int0_in(int0_in), .int1_in(int1_in),
        .adc_b_convert_start_input(adc_b_convert_start_input),
        .memif_muxed(memif_muxed), .external_data_move(external_data_move),
        .memif_claim(memif_claim), .memif_out(memif_out), .memif_drive(memif_drive),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
    ppx_pin_model ppx_pin_model_i (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_level(ext_level), .pin_in(pin_in));

    // Free-running 250 MHz clock
    initial
    begin
        forever #2 aclk = ~aclk;
    end

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Write one register; waits for the response under a bound
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic got;
        logic [1:0] resp;
        got = 1'b0;
        resp = 2'b11;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !got; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            got = bvalid;
            resp = bresp;
        end
        bready <= 1'b0;
        chk("write response", {31'h0, got}, 32'h1);
        if (!got)
            close_out();
        chk("bresp", {30'h0, resp}, {30'h0, er});
        @(posedge aclk);
    endtask : wr

    // Read one register and compare data and response
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        logic got;
        logic [31:0] d;
        logic [1:0] resp;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !got; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            got = rvalid;
            d = rdata;
            resp = rresp;
        end
        rready <= 1'b0;
        chk("read response", {31'h0, got}, 32'h1);
        if (!got)
            close_out();
        chk(what, d, ed);
        chk("rresp", {30'h0, resp}, {30'h0, er});
        @(posedge aclk);
    endtask : rdc

    // Allocation, output register and input synchronisers all settle in this time
    task automatic settle;
        repeat (5) @(posedge aclk);
    endtask : settle

    initial
    begin
        repeat (20) @(posedge aclk);
        chk("pin_oe in reset", pin_oe, 32'h0);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset state and an unmapped place
        chk("pin_pullup", pin_pullup, 32'hffffffff);
        rdc("cfg_c", ppx_pkg::ADDR_CFG_C, 32'h0, OK);
        rdc("omode0", 8'h30, 32'h0, OK);
        rdc("imode1", 8'h44, 32'hff, OK);
        rdc("unmapped", 8'h5c, 32'h0, SE);
        wr(8'h5c, 8'h00, SE);
        // Latch written while the crossbar is off
        wr(8'h24, 8'h00, OK);
        settle();
        chk("pin_oe off", pin_oe, 32'h0);
        rdc("latch1", 8'h24, 32'h0, OK);
        rdc("port1 pins", 8'h14, 32'hff, OK);
        wr(ppx_pkg::ADDR_CFG_C, 8'h10, OK);
        settle();
        chk("pin_oe on", pin_oe, 32'h0000ff00);
        chk("pin_out on", pin_out, 32'h0);
        chk("pullup low pins", pin_pullup, 32'hffff00ff);
        // First UART on bits 0 and 1, latch bit 0 still written and read back
        wr(8'h30, 8'h01, OK);
        wr(8'h20, 8'h00, OK);
        first_uart_transmit <= 1'b0;
        ext_en <= 32'h00000002;
        wr(ppx_pkg::ADDR_CFG_A, 8'h04, OK);
        settle();
        chk("p0 oe", {24'h0, pin_oe[7:0]}, 32'hfd);
        chk("tx low", {31'h0, pin_out[0]}, 32'h0);
        first_uart_transmit <= 1'b1;
        settle();
        chk("tx high", {31'h0, pin_out[0]}, 32'h1);
        chk("rx", {31'h0, first_uart_receive}, 32'h0);
        rdc("port0 pins", 8'h10, 32'h01, OK);
        rdc("latch0", 8'h20, 32'h0, OK);
        // Mode-0 receive pin stays open-drain despite push-pull
        ext_en <= 32'h0;
        first_uart_mode0 <= 1'b1;
        wr(8'h30, 8'h03, OK);
        settle();
        chk("mode0 rx oe", {31'h0, pin_oe[1]}, 32'h0);
        first_uart_mode0 <= 1'b0;
        // Full serial set with the memory reservation
        wr(8'h20, 8'hff, OK);
        wr(8'h30, 8'h1f, OK);
        second_uart_transmit <= 1'b0;
        memif_muxed <= 1'b1;
        ext_en <= 32'h00000100;
        wr(ppx_pkg::ADDR_CFG_A, 8'h05, OK);
        wr(ppx_pkg::ADDR_CFG_C, 8'h34, OK);
        settle();
        chk("oe p0 p1", {16'h0, pin_oe[15:0]}, 32'hfe11);
        chk("out p0 p1", {16'h0, pin_out[15:0]}, 32'h0001);
        chk("rx2 on p1.0", {31'h0, second_uart_receive}, 32'h0);
        memif_muxed <= 1'b0;
        settle();
        chk("rx2 on p0.5", {31'h0, second_uart_receive}, 32'h1);
        chk("p1.0 gpio", {31'h0, pin_oe[8]}, 32'h1);
        memif_muxed <= 1'b1;
        // Memory move claims bits 7..5, then a read releases them
        external_data_move <= 1'b1;
        memif_claim <= 32'h000000e0;
        memif_drive <= 32'h000000e0;
        settle();
        chk("move oe", {29'h0, pin_oe[7:5]}, 32'h7);
        chk("move out", {29'h0, pin_out[7:5]}, 32'h0);
        memif_drive <= 32'h0;
        settle();
        chk("move read oe", {29'h0, pin_oe[7:5]}, 32'h0);
        external_data_move <= 1'b0;
        // Analog pin parked, skipped and read as 0
        wr(8'h24, 8'hff, OK);
        ext_en <= 32'h00000200;
        wr(8'h44, 8'hfe, OK);
        settle();
        chk("analog pullup", {31'h0, pin_pullup[8]}, 32'h0);
        chk("rx2 on p1.1", {31'h0, second_uart_receive}, 32'h0);
        rdc("port1 analog", 8'h14, 32'hfc, OK);
        wr(ppx_pkg::ADDR_CFG_C, 8'hb4, OK);
        settle();
        chk("pullups off", pin_pullup, 32'h0);
        // Single-bit access on port 2 bit 0
        wr(8'hc0, 8'h00, OK);
        settle();
        rdc("latch2", 8'h28, 32'hfe, OK);
        chk("p2.0 drive", {30'h0, pin_oe[16], pin_out[16]}, 32'h2);
        rdc("bit16", 8'hc0, 32'h0, OK);
        // Disabled peripherals lose their pins
        wr(ppx_pkg::ADDR_CFG_A, 8'h00, OK);
        settle();
        chk("rx unmapped", {31'h0, first_uart_receive}, 32'h1);
        chk("uart2 on p0", {30'h0, pin_oe[1:0]}, 32'h1);
        // Input-only signals land on bits 2..4 behind the second UART and stay undriven
        ext_en <= 32'h0000001c;
        ext_level <= 32'h00000014;
        wr(ppx_pkg::ADDR_CFG_B, 8'h14, OK);
        wr(ppx_pkg::ADDR_CFG_C, 8'hb5, OK);
        settle();
        chk("input pins oe", {29'h0, pin_oe[4:2]}, 32'h0);
        chk("int and convert", {29'h0, int0_in, int1_in, adc_b_convert_start_input}, 32'h5);
        chk("smbus unmapped", {30'h0, sda_in, scl_in}, 32'h3);
        close_out();
    end
endmodule : priority_port_crossbar_test
`default_nettype wire
